// >>> ecb_cfg.svh
// Constants of the edge up-counter bank: sizes, entry layout, register map.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef ECB_CFG_SVH
`define ECB_CFG_SVH

// ----------------------------------------
// Bank size and count range
// ----------------------------------------
`define ECB_NUM_COUNTERS 2048
`define ECB_IDX_W 11
`define ECB_CNT_W 16
`define ECB_CNT_MAX 16'hFFFF

// ----------------------------------------
// Layout of one stored counter entry
// ----------------------------------------
`define ECB_ENT_W 18
`define ECB_ENT_EV_LSB 0
`define ECB_ENT_EV_MSB 15
`define ECB_ENT_PREV 16
`define ECB_ENT_COIL 17

// ----------------------------------------
// Register map: one word per counter
// ----------------------------------------
`define ECB_ADDR_IDX_LSB 2
`define ECB_ADDR_IDX_MSB 12
`define ECB_ADDR_HI_LSB 13
`define ECB_RD_COIL_BIT 16
`define ECB_RESP_OKAY 2'h0
`define ECB_RESP_SLVERR 2'h2

`endif

// >>> ecb_pkg.sv
// Types shared by the edge up-counter bank.
// Assumes nothing of its surroundings.
`default_nettype none

package ecb_pkg;

    // ----------------------------------------
    // Sequencer states, one-hot
    // ----------------------------------------
    typedef enum logic [4:0] {
        ECB_ST_INIT = 5'h01,
        ECB_ST_IDLE = 5'h02,
        ECB_ST_EVAL = 5'h04,
        ECB_ST_WMERGE = 5'h08,
        ECB_ST_RDATA = 5'h10
    } ecb_state_t;

endpackage

`default_nettype wire

// >>> ecb_mem.sv
// Single-port storage for the counter entries.
// Assumes one access per cycle; read data appear one cycle after the address.
`timescale 1ns/100ps
`default_nettype none

module ecb_mem #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 2048,
    parameter int AW = 11
) (
    input wire logic mclk,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] store [0:DEPTH-1];

    // ----------------------------------------
    // Write-first is not needed: a slot is never read in its write cycle
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (we) begin
            store[addr] <= wdata;
        end
    end

    always_ff @(posedge mclk) begin
        rdata <= store[addr];
    end

endmodule

`default_nettype wire

// >>> ecb_counter_bank.sv
// Bank of edge-triggered up counters sharing one entry store, with an
// AXI4-Lite port onto each counter's elapsed value.
// Assumes the ladder sequencer runs on mclk and drives the scan inputs
// directly, and that each counter index is never also used as a timer.
//
// How it works
// - 2048 counters, indexes 0 to 2047, held in one shared entry store.
// - Each evaluation takes an unsigned 16-bit set value, constant or word.
// - A detected rising edge of start adds exactly one to elapsed value.
// - Coil is on whenever elapsed value is at or above set value.
// - Clear drops the coil and zeroes the elapsed value.
// - Elapsed value stops at 65535 and never wraps.
// - Each elapsed value reads back as that counter's bus word.
// - A bus write of elapsed value is counted and compared from onward.
// - Set value is taken afresh at every evaluation.
// - While clear is on, start edges are ignored and count held at zero.
// - Start already high in the first scan after run is no edge.
// - Elapsed value changes only when that counter's coil is evaluated or a bus write merges into it.
// - Set value zero keeps the coil on unless clear holds it off.
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "ecb_cfg.svh"

module ecb_counter_bank #(
    parameter int NUM_COUNTERS = `ECB_NUM_COUNTERS,
    parameter int IDX_W = `ECB_IDX_W,
    parameter int CNT_W = `ECB_CNT_W
) (
    input wire logic mclk,
    input wire logic reset,
    // Ladder side: one counter coil evaluation per accepted strobe
    input wire logic scan_strobe,
    output logic scan_ready,
    input wire logic [IDX_W-1:0] scan_index,
    input wire logic scan_start_in,
    input wire logic count_clear_in,
    input wire logic [CNT_W-1:0] scan_set_value,
    input wire logic first_scan_flag,
    output logic count_coil_out,
    output logic [CNT_W-1:0] elapsed_value_word,
    output logic [IDX_W-1:0] result_index,
    output logic result_valid,
    // AXI4-Lite slave
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    ecb_pkg::ecb_state_t state_q;
    ecb_pkg::ecb_state_t state_d;
    logic [IDX_W-1:0] init_idx_q;
    logic [IDX_W-1:0] op_idx_q;
    logic op_start_q;
    logic op_clear_q;
    logic op_first_q;
    logic [CNT_W-1:0] op_set_q;
    logic [31:0] aw_addr_q;
    logic aw_full_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic w_full_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic coil_q;
    logic [CNT_W-1:0] ev_out_q;
    logic [IDX_W-1:0] res_idx_q;
    logic res_valid_q;

    logic take_scan;
    logic take_wr;
    logic take_rd;
    logic aw_ok;
    logic ar_ok;
    logic mem_we;
    logic [IDX_W-1:0] mem_addr;
    logic [`ECB_ENT_W-1:0] mem_wdata;
    logic [`ECB_ENT_W-1:0] mem_rdata;
    logic [CNT_W-1:0] old_ev;
    logic rise;
    logic [CNT_W-1:0] eval_ev;
    logic eval_coil;
    logic [CNT_W-1:0] merge_ev;

    // ----------------------------------------
    // Request selection
    // ----------------------------------------
    // Scan evaluations win over bus traffic in IDLE, so software delays a scan
    // by at most one cycle; a busy scan can starve the bus.
    assign aw_ok = (aw_addr_q[31:`ECB_ADDR_HI_LSB] == '0);
    assign ar_ok = (s_axi_araddr[31:`ECB_ADDR_HI_LSB] == '0);
    assign take_scan = (state_q == ecb_pkg::ECB_ST_IDLE) && scan_strobe;
    assign take_wr = (state_q == ecb_pkg::ECB_ST_IDLE) && !scan_strobe
                     && aw_full_q && w_full_q && !bvalid_q;
    assign take_rd = (state_q == ecb_pkg::ECB_ST_IDLE) && !scan_strobe && !take_wr
                     && s_axi_arvalid && !rvalid_q;
    assign scan_ready = (state_q == ecb_pkg::ECB_ST_IDLE);

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ecb_pkg::ECB_ST_INIT: begin
                if (init_idx_q == IDX_W'(NUM_COUNTERS - 1)) begin
                    state_d = ecb_pkg::ECB_ST_IDLE;
                end
            end
            ecb_pkg::ECB_ST_IDLE: begin
                if (take_scan) begin
                    state_d = ecb_pkg::ECB_ST_EVAL;
                end else if (take_wr && aw_ok) begin
                    state_d = ecb_pkg::ECB_ST_WMERGE;
                end else if (take_rd && ar_ok) begin
                    state_d = ecb_pkg::ECB_ST_RDATA;
                end
            end
            ecb_pkg::ECB_ST_EVAL: state_d = ecb_pkg::ECB_ST_IDLE;
            ecb_pkg::ECB_ST_WMERGE: state_d = ecb_pkg::ECB_ST_IDLE;
            ecb_pkg::ECB_ST_RDATA: state_d = ecb_pkg::ECB_ST_IDLE;
            default: state_d = ecb_pkg::ECB_ST_INIT;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q <= ecb_pkg::ECB_ST_INIT;
        end else begin
            state_q <= state_d;
        end
    end

    // Zero every entry after reset; the store itself has no reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            init_idx_q <= '0;
        end else if (state_q == ecb_pkg::ECB_ST_INIT) begin
            init_idx_q <= init_idx_q + IDX_W'(1);
        end
    end

    // ----------------------------------------
    // Captured operation
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            op_idx_q <= '0;
            op_start_q <= 1'b0;
            op_clear_q <= 1'b0;
            op_first_q <= 1'b0;
            op_set_q <= '0;
        end else if (take_scan) begin
            op_idx_q <= scan_index;
            op_start_q <= scan_start_in;
            op_clear_q <= count_clear_in;
            op_first_q <= first_scan_flag;
            op_set_q <= scan_set_value;
        end else if (take_wr) begin
            op_idx_q <= aw_addr_q[`ECB_ADDR_IDX_MSB:`ECB_ADDR_IDX_LSB];
        end else if (take_rd) begin
            op_idx_q <= s_axi_araddr[`ECB_ADDR_IDX_MSB:`ECB_ADDR_IDX_LSB];
        end
    end

    // ----------------------------------------
    // Counter evaluation
    // ----------------------------------------
    assign old_ev = mem_rdata[`ECB_ENT_EV_MSB:`ECB_ENT_EV_LSB];
    // No earlier sample exists in the first scan, so a high start is no edge
    assign rise = op_start_q && !mem_rdata[`ECB_ENT_PREV] && !op_first_q;

    always_comb begin
        if (op_clear_q) begin
            eval_ev = '0;
        end else if (rise && old_ev != `ECB_CNT_MAX) begin
            eval_ev = old_ev + CNT_W'(1);
        end else begin
            eval_ev = old_ev;
        end
    end

    // A set value of zero always compares true, so only clear holds it off
    assign eval_coil = !op_clear_q && (eval_ev >= op_set_q);

    // Byte lanes 0 and 1 of a bus write land on the stored elapsed value
    always_comb begin
        merge_ev = old_ev;
        for (int b = 0; b < CNT_W / 8; b++) begin
            if (w_strb_q[b]) begin
                merge_ev[b*8 +: 8] = w_data_q[b*8 +: 8];
            end
        end
    end

    // ----------------------------------------
    // Entry store port
    // ----------------------------------------
    always_comb begin
        mem_we = 1'b0;
        mem_addr = op_idx_q;
        mem_wdata = '0;
        case (state_q)
            ecb_pkg::ECB_ST_INIT: begin
                mem_we = 1'b1;
                mem_addr = init_idx_q;
            end
            ecb_pkg::ECB_ST_IDLE: begin
                if (take_scan) begin
                    mem_addr = scan_index;
                end else if (take_wr) begin
                    mem_addr = aw_addr_q[`ECB_ADDR_IDX_MSB:`ECB_ADDR_IDX_LSB];
                end else begin
                    mem_addr = s_axi_araddr[`ECB_ADDR_IDX_MSB:`ECB_ADDR_IDX_LSB];
                end
            end
            ecb_pkg::ECB_ST_EVAL: begin
                // A count moves only here, at the coil evaluation, and in WMERGE by a bus write
                mem_we = 1'b1;
                mem_wdata = {eval_coil, op_start_q, eval_ev};
            end
            ecb_pkg::ECB_ST_WMERGE: begin
                // Edge history is kept, so counting resumes from the new value
                mem_we = 1'b1;
                mem_wdata = {mem_rdata[`ECB_ENT_COIL], mem_rdata[`ECB_ENT_PREV], merge_ev};
            end
            default: mem_we = 1'b0;
        endcase
    end

    ecb_mem #(
        .WIDTH(`ECB_ENT_W),
        .DEPTH(NUM_COUNTERS),
        .AW(IDX_W)
    ) u_store (
        .mclk(mclk),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // ----------------------------------------
    // Ladder-side results
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            coil_q <= 1'b0;
            ev_out_q <= '0;
            res_idx_q <= '0;
        end else if (state_q == ecb_pkg::ECB_ST_EVAL) begin
            coil_q <= eval_coil;
            ev_out_q <= eval_ev;
            res_idx_q <= op_idx_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            res_valid_q <= 1'b0;
        end else begin
            res_valid_q <= (state_q == ecb_pkg::ECB_ST_EVAL);
        end
    end

    assign count_coil_out = coil_q;
    assign elapsed_value_word = ev_out_q;
    assign result_index = res_idx_q;
    assign result_valid = res_valid_q;

    // ----------------------------------------
    // AXI4-Lite write channels
    // ----------------------------------------
    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready = !w_full_q;

    always_ff @(posedge mclk) begin
        if (reset) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (take_wr) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            w_full_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (take_wr) begin
            w_full_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            bvalid_q <= 1'b0;
            bresp_q <= `ECB_RESP_OKAY;
        end else if (take_wr && !aw_ok) begin
            bvalid_q <= 1'b1;
            bresp_q <= `ECB_RESP_SLVERR;
        end else if (state_q == ecb_pkg::ECB_ST_WMERGE) begin
            bvalid_q <= 1'b1;
            bresp_q <= `ECB_RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ----------------------------------------
    // AXI4-Lite read channels
    // ----------------------------------------
    assign s_axi_arready = take_rd;

    always_ff @(posedge mclk) begin
        if (reset) begin
            rvalid_q <= 1'b0;
            rresp_q <= `ECB_RESP_OKAY;
            rdata_q <= '0;
        end else if (take_rd && !ar_ok) begin
            rvalid_q <= 1'b1;
            rresp_q <= `ECB_RESP_SLVERR;
            rdata_q <= '0;
        end else if (state_q == ecb_pkg::ECB_ST_RDATA) begin
            rvalid_q <= 1'b1;
            rresp_q <= `ECB_RESP_OKAY;
            rdata_q <= '0;
            rdata_q[`ECB_CNT_W-1:0] <= old_ev;
            rdata_q[`ECB_RD_COIL_BIT] <= mem_rdata[`ECB_ENT_COIL];
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

endmodule

`default_nettype wire

// >>> ecb_counter_bank_asserts.sv
// Port-level checks of the counter bank, bound into every instance.
// Assumes mclk and the synchronous active-high reset of the bank.
`timescale 1ns/100ps
`default_nettype none

module ecb_counter_bank_asserts #(
    parameter int IDX_W = 11,
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic scan_strobe,
    input wire logic scan_ready,
    input wire logic [IDX_W-1:0] scan_index,
    input wire logic count_clear_in,
    input wire logic [CNT_W-1:0] scan_set_value,
    input wire logic count_coil_out,
    input wire logic [CNT_W-1:0] elapsed_value_word,
    input wire logic [IDX_W-1:0] result_index,
    input wire logic result_valid,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    wire take = scan_strobe & scan_ready;

    a_ready_drop: assert property (take |=> !scan_ready)
        else $error("ready high after take");
    a_result_lat: assert property (take |-> ##2 result_valid)
        else $error("result late");
    a_result_cause: assert property (result_valid |-> $past(take, 2)
        && result_index == $past(scan_index, 2)) else $error("result without take");
    a_coil_rule: assert property (
        result_valid |-> count_coil_out == (!$past(count_clear_in, 2)
        && elapsed_value_word >= $past(scan_set_value, 2))) else $error("coil wrong");
    a_clear_zero: assert property (
        take && count_clear_in |-> ##2 elapsed_value_word == 0) else $error("clear kept count");
    a_result_hold: assert property (
        !result_valid |-> $stable(elapsed_value_word) && $stable(count_coil_out))
        else $error("result moved");
    a_rvalid_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_rd_unmapped: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr[31:13] != 0
        |=> s_axi_rvalid && s_axi_rresp == 2'h2) else $error("unmapped read");

    c_clear: cover property (take && count_clear_in);
    c_ceiling: cover property (result_valid && elapsed_value_word == 16'hFFFF);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind ecb_counter_bank ecb_counter_bank_asserts #(.IDX_W(IDX_W), .CNT_W(CNT_W)) u_chk (
    .mclk, .reset, .scan_strobe, .scan_ready, .scan_index, .count_clear_in,
    .scan_set_value, .count_coil_out, .elapsed_value_word, .result_index,
    .result_valid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// >>> ecb_ladder_model.sv
// Ladder program side: one coil evaluation per call of scan.
// Assumes mclk of the bank; indexes never double as timers.
`timescale 1ns/100ps
`default_nettype none

module ecb_ladder_model (
    input wire logic mclk,
    input wire logic scan_ready,
    output logic scan_strobe,
    output logic [10:0] scan_index,
    output logic scan_start_in,
    output logic count_clear_in,
    output logic [15:0] scan_set_value,
    output logic first_scan_flag
);
    initial begin
        scan_strobe = 1'b0;
        {scan_index, scan_start_in, count_clear_in, scan_set_value, first_scan_flag} = '0;
    end

    task automatic scan(input logic [10:0] i, input logic st, cl, input logic [15:0] sv,
        input logic fs, output logic ok);
        int n;
        @(posedge mclk);
        scan_strobe <= 1'b1;
        scan_index <= i;
        scan_start_in <= st;
        count_clear_in <= cl;
        scan_set_value <= sv;
        first_scan_flag <= fs;
        ok = 1'b0;
        for (n = 0; n < 5000 && !ok; n++) begin
            @(negedge mclk);
            ok = scan_ready;
            @(posedge mclk);
        end
        // Released lines show garbage, not the last value
        scan_strobe <= 1'b0;
        {scan_index, scan_start_in, count_clear_in, scan_set_value, first_scan_flag} <=
            ~{i, st, cl, sv, fs};
    endtask
endmodule
`default_nettype wire

// >>> tb_ecb_counter_bank.sv
// Self-checking bench of the counter bank: scans through the ladder model, AXI by tasks.
// Assumes the default bank size, so the 2048-cycle store sweep runs after reset.
`timescale 1ns/100ps
`default_nettype none

module tb_ecb_counter_bank;
    logic mclk, reset, scan_strobe, scan_ready, scan_start_in, count_clear_in;
    logic first_scan_flag, count_coil_out, result_valid;
    logic [10:0] scan_index, result_index;
    logic [15:0] scan_set_value, elapsed_value_word;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int errors, n_checks, k, i, c;
    logic [33:0] sq[$], rq[$], bq[$];
    int ev[2048];
    bit pv[2048], cv[2048];
    wire [27:0] res = {result_index, count_coil_out, elapsed_value_word};

    ecb_counter_bank DUT (.mclk, .reset, .scan_strobe, .scan_ready, .scan_index,
        .scan_start_in, .count_clear_in, .scan_set_value, .first_scan_flag,
        .count_coil_out, .elapsed_value_word, .result_index, .result_valid,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    ecb_ladder_model lad (.mclk, .scan_ready, .scan_strobe, .scan_index, .scan_start_in,
        .count_clear_in, .scan_set_value, .first_scan_flag);

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic chk(input logic [33:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic fail;
        errors++;
        $display("wait bound used up at %0t", $time);
        summarize();
    endtask

    // Reference counter updated before the scan is driven
    task automatic sc(input int i, input bit st, cl, input int sv, input bit fs);
        logic ok;
        if (cl) begin
            ev[i] = 0;
            cv[i] = 0;
        end else begin
            if (st && !pv[i] && !fs && ev[i] < 65535) ev[i]++;
            cv[i] = ev[i] >= sv;
        end
        pv[i] = st;
        sq.push_back({i[10:0], cv[i], ev[i][15:0]});
        lad.scan(i[10:0], st, cl, sv[15:0], fs, ok);
        if (!ok) fail();
    endtask

    task automatic axw(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] r);
        int n;
        logic ah, wh, bh;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        bq.push_back(r);
        for (n = 0; n < 5000; n++) begin
            @(negedge mclk);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            bh = s_axi_bvalid;
            @(posedge mclk);
            // Released payload turns to junk so a late sample would show
            if (ah) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (wh) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
            if (bh) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 5000) fail();
    endtask

    // Ready raised only once data waits, so the slave must hold it
    task automatic axr(input logic [31:0] a, input logic [33:0] e);
        int n;
        logic hit, got;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        rq.push_back(e);
        for (n = 0; n < 5000; n++) begin
            @(negedge mclk);
            hit = s_axi_arvalid && s_axi_arready;
            got = s_axi_rvalid;
            @(posedge mclk);
            if (hit) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
            if (got && s_axi_rready) break;
            if (got) s_axi_rready <= 1'b1;
        end
        s_axi_rready <= 1'b0;
        if (n == 5000) fail();
    endtask

    int i_list[4] = '{0, 1, 2, 2047};

    always @(negedge mclk) begin
        if (result_valid === 1'b1) chk(res, sq.pop_front());
        if (s_axi_rvalid === 1'b1 && s_axi_rready)
            chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid === 1'b1 && s_axi_bready)
            chk(s_axi_bresp, bq.pop_front());
    end

    initial begin
        reset = 1'b1;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        void'($urandom(32'hD3A7));
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        sc(5, 1, 0, 3, 1);
        sc(5, 0, 0, 3, 0);
        for (k = 0; k < 5; k++) sc(5, ~k[0], 0, 3, 0);
        sc(5, 1, 1, 3, 0);
        sc(5, 0, 0, 0, 0);
        $display("test scan basics done");
        axw(32'h24, 32'h0000FFFE, 4'h3, 2'h0);
        ev[9] = 32'hFFFE;
        for (k = 0; k < 6; k++) sc(9, k[0], 0, 32'hFFFF, 0);
        axr(32'h24, {2'h0, 15'h0, 1'b1, 16'hFFFF});
        axw(32'h24, 32'h12345612, 4'h1, 2'h0);
        ev[9] = 32'hFF12;
        axr(32'h24, {2'h0, 15'h0, cv[9], 16'hFF12});
        axr(32'h2000, {2'h2, 32'h0});
        axw(32'h4000, 32'h1, 4'hF, 2'h2);
        $display("test bus access done");
        for (k = 0; k < 60; k++) begin
            i = $urandom_range(3);
            if (i == 3) i = 2047;
            c = ($urandom_range(7) == 0);
            sc(i, c ? 1'b0 : 1'($urandom_range(1)), c[0], $urandom_range(4), 0);
        end
        foreach (i_list[j]) axr(i_list[j] * 4, {2'h0, 15'h0, cv[i_list[j]], ev[i_list[j]][15:0]});
        $display("test random scans done");
        repeat (10) @(posedge mclk);
        chk(sq.size() + rq.size() + bq.size(), 0);
        summarize();
    end
endmodule
`default_nettype wire
